// ==== include/prs_pkg.sv ====
// Constants, register map and field layout of the pin route selector
//
// Operation
// R1 - Event output A: PA2 default, PA7 alternate
// R2 - Event output B: PB2 only, set reserved
// R3 - Event output C: PC2 default, PC7 alternate
// R4 - Event output D: PD2 default, PD7 alternate
// R5 - Event output E: PE2 only, set reserved
// R6 - Event output F: PF2 only, set reserved
// R7 - Logic table 0: PA3 default, PA6 alternate
// R8 - Logic table 1: PC3 default, PC6 alternate
// R9 - Logic table 2: PD3 default, PD6 alternate
// R10 - Logic table 3: PF3 default, PF6 alternate
// R11 - Serial port 3 pin set, bits 7:6
// R12 - Serial ports 0-2 pin sets, bits 1:0/3:2/5:4
// R13 - Reset zero; unused bits read zero
package prs_pkg;

  // Printed offsets are not multiples of four: indices, byte address is four times
  localparam logic [1:0] PRS_IDX_EVENT_OUTPUT_ROUTE        = 2'h0;
  localparam logic [1:0] PRS_IDX_LOGIC_TABLE_OUTPUT_ROUTE  = 2'h1;
  localparam logic [1:0] PRS_IDX_SERIAL_PORT_PIN_ROUTE     = 2'h2;
  localparam int         PRS_ADDR_W                        = 4;
  localparam logic [3:0] PRS_ADDR_EVENT                    = 4'h0;
  localparam logic [3:0] PRS_ADDR_LOGIC                    = 4'h4;
  localparam logic [3:0] PRS_ADDR_SERIAL                   = 4'h8;

  // Writable bits per register
  localparam logic [7:0] PRS_EVENT_MASK  = 8'h3F;
  localparam logic [7:0] PRS_LOGIC_MASK  = 8'h0F;
  localparam logic [7:0] PRS_SERIAL_MASK = 8'hFF;
  localparam logic [7:0] PRS_REG_RESET   = 8'h00;

  // Event output field positions
  localparam int PRS_EV_A = 0;
  localparam int PRS_EV_B = 1;
  localparam int PRS_EV_C = 2;
  localparam int PRS_EV_D = 3;
  localparam int PRS_EV_E = 4;
  localparam int PRS_EV_F = 5;
  // Serial pin-set field lsbs
  localparam int PRS_SER0_LSB = 0;
  localparam int PRS_SER1_LSB = 2;
  localparam int PRS_SER2_LSB = 4;
  localparam int PRS_SER3_LSB = 6;

  localparam logic [1:0] PRS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PRS_RESP_SLVERR = 2'h2;

endpackage

// ==== include/prs_route_if.sv ====
// Carrier for one two-position routed output
`timescale 1ns/100ps
interface prs_route_if;
  logic sel;
  logic sig;
  logic pin_dflt;
  logic pin_alt;
  modport ctrl (output sel, output sig, input pin_dflt, input pin_alt);
  modport mux  (input sel, input sig, output pin_dflt, output pin_alt);
endinterface

// ==== rtl/prs_route2.sv ====
// Two-position output steering cell
`timescale 1ns/100ps
module prs_route2 (
  input  wire logic aclk,
  input  wire logic aresetn,
  prs_route_if.mux  rt
);
  // Unselected position stays low so only one pin carries the signal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rt.pin_dflt <= 1'b0;
      rt.pin_alt  <= 1'b0;
    end else begin
      rt.pin_dflt <= rt.sig & ~rt.sel;
      rt.pin_alt  <= rt.sig & rt.sel;
    end
  end
endmodule

// ==== rtl/prs_pin_route_select.sv ====
// Pin route selector: AXI4-Lite registers and output steering
`timescale 1ns/100ps
module prs_pin_route_select
  import prs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [5:0]  event_out,
  input  wire logic [3:0]  logic_table_out,
  output logic             pa2_event_a,
  output logic             pa7_event_a,
  output logic             pb2_event_b,
  output logic             pc2_event_c,
  output logic             pc7_event_c,
  output logic             pd2_event_d,
  output logic             pd7_event_d,
  output logic             pe2_event_e,
  output logic             pf2_event_f,
  output logic [3:0]       logic_table_dflt_pin,
  output logic [3:0]       logic_table_alt_pin,
  output logic [1:0]       serial0_pin_set,
  output logic [1:0]       serial1_pin_set,
  output logic [1:0]       serial2_pin_set,
  output logic [1:0]       serial3_pin_set
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] event_output_route_q;
  logic [7:0] logic_table_output_route_q;
  logic [7:0] serial_port_pin_route_q;

  logic        aw_held_q;
  logic        w_held_q;
  logic [3:0]  aw_addr_q;
  logic [7:0]  w_byte_q;
  logic        w_lane0_q;
  logic        do_write;

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  // Address and data taken in either order, held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr_q     <= 4'h0;
    end else begin
      s_axi_awready <= 1'b0;
      if (s_axi_awvalid && !s_axi_awready && !aw_held_q) begin
        s_axi_awready <= 1'b1;
        aw_held_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q     <= 1'b0;
      s_axi_wready <= 1'b0;
      w_byte_q     <= 8'h00;
      w_lane0_q    <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (s_axi_wvalid && !s_axi_wready && !w_held_q) begin
        s_axi_wready <= 1'b1;
        w_held_q     <= 1'b1;
        w_byte_q     <= s_axi_wdata[7:0];
        w_lane0_q    <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  logic aw_mapped;
  assign aw_mapped = (aw_addr_q == PRS_ADDR_EVENT) || (aw_addr_q == PRS_ADDR_LOGIC)
                  || (aw_addr_q == PRS_ADDR_SERIAL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PRS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_mapped ? PRS_RESP_OKAY : PRS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Reserved alternate codes of B, E, F are masked off: they cannot be stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_output_route_q <= PRS_REG_RESET;        // [R13]
    end else if (do_write && w_lane0_q && aw_addr_q == PRS_ADDR_EVENT) begin
      event_output_route_q <= w_byte_q & PRS_EVENT_MASK
                            & ~(8'h01 << PRS_EV_B) & ~(8'h01 << PRS_EV_E)
                            & ~(8'h01 << PRS_EV_F); // [R2] [R5] [R6] [R13]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      logic_table_output_route_q <= PRS_REG_RESET;  // [R13]
    end else if (do_write && w_lane0_q && aw_addr_q == PRS_ADDR_LOGIC) begin
      logic_table_output_route_q <= w_byte_q & PRS_LOGIC_MASK; // [R13]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_port_pin_route_q <= PRS_REG_RESET;     // [R13]
    end else if (do_write && w_lane0_q && aw_addr_q == PRS_ADDR_SERIAL) begin
      serial_port_pin_route_q <= w_byte_q & PRS_SERIAL_MASK;
    end
  end

  // Write path checks, judged on the edge after the beat lands
  chk_aw_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    s_axi_awready |=> !s_axi_awready)
    else $error("address ready held high");

  chk_w_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    s_axi_wready |=> !s_axi_wready)
    else $error("data ready held high");

  chk_write_okay: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    do_write && aw_mapped |=> s_axi_bvalid && s_axi_bresp == PRS_RESP_OKAY)
    else $error("mapped write not answered okay");

  chk_unmapped_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    do_write && !aw_mapped |=> s_axi_bresp == PRS_RESP_SLVERR && $stable(event_output_route_q)
      && $stable(logic_table_output_route_q) && $stable(serial_port_pin_route_q))
    else $error("unmapped write not refused");

  chk_lane0_ignored: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    do_write && !w_lane0_q |=> $stable(event_output_route_q)
      && $stable(logic_table_output_route_q) && $stable(serial_port_pin_route_q))
    else $error("write without lane 0 changed a route");

  chk_event_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R2] [R5] [R6]
    do_write && w_lane0_q && aw_addr_q == PRS_ADDR_EVENT
      |=> event_output_route_q == ($past(w_byte_q) & 8'h0D))
    else $error("event route write wrong");

  chk_logic_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    do_write && w_lane0_q && aw_addr_q == PRS_ADDR_LOGIC
      |=> logic_table_output_route_q == {4'h0, $past(w_byte_q[3:0])})
    else $error("logic table route write wrong");

  chk_serial_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    do_write && w_lane0_q && aw_addr_q == PRS_ADDR_SERIAL
      |=> serial_port_pin_route_q == $past(w_byte_q))
    else $error("serial route write wrong");

  chk_reset_clears: assert property (@(posedge aclk) // [R13]
    !aresetn |=> event_output_route_q == PRS_REG_RESET && logic_table_output_route_q == PRS_REG_RESET
      && serial_port_pin_route_q == PRS_REG_RESET && !s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("reset left routing state set");

  ////////////////////////////////////////////////////////////////////////////
  // Read channel, data valid in the same cycle as the address ready

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= PRS_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= PRS_RESP_OKAY;
        unique case (s_axi_araddr)
          PRS_ADDR_EVENT:  s_axi_rdata <= {24'h000000, event_output_route_q};
          PRS_ADDR_LOGIC:  s_axi_rdata <= {24'h000000, logic_table_output_route_q};
          PRS_ADDR_SERIAL: s_axi_rdata <= {24'h000000, serial_port_pin_route_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PRS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  chk_ar_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    s_axi_arready |-> s_axi_rvalid ##1 !s_axi_arready)
    else $error("read address ready without data");

  chk_read_upper: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  chk_read_refused: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    s_axi_rvalid && s_axi_rresp == PRS_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read returned data");

  ////////////////////////////////////////////////////////////////////////////
  // Steering of event outputs and logic table outputs

  prs_route_if ev_rt [3] ();
  prs_route_if lt_rt [4] ();
  localparam int EV_POS [3] = '{PRS_EV_A, PRS_EV_C, PRS_EV_D};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ev
      assign ev_rt[gi].sel = event_output_route_q[EV_POS[gi]]; // [R1] [R3] [R4]
      assign ev_rt[gi].sig = event_out[EV_POS[gi]];
      prs_route2 u_ev (.aclk(aclk), .aresetn(aresetn), .rt(ev_rt[gi]));
    end
    for (gi = 0; gi < 4; gi++) begin : g_lt
      assign lt_rt[gi].sel = logic_table_output_route_q[gi]; // [R7] [R8] [R9] [R10]
      assign lt_rt[gi].sig = logic_table_out[gi];
      prs_route2 u_lt (.aclk(aclk), .aresetn(aresetn), .rt(lt_rt[gi]));
      assign logic_table_dflt_pin[gi] = lt_rt[gi].pin_dflt;
      assign logic_table_alt_pin[gi]  = lt_rt[gi].pin_alt;
    end
  endgenerate

  assign pa2_event_a = ev_rt[0].pin_dflt; // [R1]
  assign pa7_event_a = ev_rt[0].pin_alt;  // [R1]
  assign pc2_event_c = ev_rt[1].pin_dflt; // [R3]
  assign pc7_event_c = ev_rt[1].pin_alt;  // [R3]
  assign pd2_event_d = ev_rt[2].pin_dflt; // [R4]
  assign pd7_event_d = ev_rt[2].pin_alt;  // [R4]

  // B, E, F have only their default pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb2_event_b <= 1'b0;
      pe2_event_e <= 1'b0;
      pf2_event_f <= 1'b0;
    end else begin
      pb2_event_b <= event_out[PRS_EV_B]; // [R2]
      pe2_event_e <= event_out[PRS_EV_E]; // [R5]
      pf2_event_f <= event_out[PRS_EV_F]; // [R6]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial0_pin_set <= 2'h0;
      serial1_pin_set <= 2'h0;
      serial2_pin_set <= 2'h0;
      serial3_pin_set <= 2'h0;
    end else begin
      serial0_pin_set <= serial_port_pin_route_q[PRS_SER0_LSB +: 2]; // [R12]
      serial1_pin_set <= serial_port_pin_route_q[PRS_SER1_LSB +: 2]; // [R12]
      serial2_pin_set <= serial_port_pin_route_q[PRS_SER2_LSB +: 2]; // [R12]
      serial3_pin_set <= serial_port_pin_route_q[PRS_SER3_LSB +: 2]; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Pin checks start after the release edge; the reset edge clears pins instead

  chk_event_b_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // [R2] [R5] [R6]
    !event_output_route_q[PRS_EV_B] && !event_output_route_q[PRS_EV_E]
    && !event_output_route_q[PRS_EV_F])
    else $error("reserved event route bit stored");

  chk_event_a_pins: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    aresetn |=> (pa7_event_a == ($past(event_out[PRS_EV_A]) && $past(event_output_route_q[PRS_EV_A])))
    && (pa2_event_a == ($past(event_out[PRS_EV_A]) && !$past(event_output_route_q[PRS_EV_A]))))
    else $error("event A on wrong pin");

  chk_event_c_pins: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    (aresetn && event_out[PRS_EV_C] && event_output_route_q[PRS_EV_C]) |=> pc7_event_c && !pc2_event_c)
    else $error("event C not on alternate pin");

  chk_event_d_pins: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    (aresetn && event_out[PRS_EV_D] && !event_output_route_q[PRS_EV_D]) |=> pd2_event_d && !pd7_event_d)
    else $error("event D not on default pin");

  chk_event_ef_dflt: assert property (@(posedge aclk) disable iff (!aresetn) // [R5] [R6]
    aresetn |=> pe2_event_e == $past(event_out[PRS_EV_E]) && pf2_event_f == $past(event_out[PRS_EV_F]))
    else $error("event E or F pin mismatch");

  chk_table_alt_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [R7] [R8] [R9] [R10]
    aresetn |=> logic_table_alt_pin == ($past(logic_table_out) & $past(logic_table_output_route_q[3:0])))
    else $error("logic table alternate pins wrong");

  chk_table_dflt_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [R7] [R8] [R9] [R10]
    aresetn |=> logic_table_dflt_pin == ($past(logic_table_out) & ~$past(logic_table_output_route_q[3:0])))
    else $error("logic table default pins wrong");

  chk_serial3_field: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    aresetn |=> serial3_pin_set == $past(serial_port_pin_route_q[7:6]) && serial0_pin_set
      == $past(serial_port_pin_route_q[1:0]))
    else $error("serial pin set field mismatch");

  chk_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    event_output_route_q[7:6] == 2'h0 && logic_table_output_route_q[7:4] == 4'h0)
    else $error("unused route bits not zero");

  chk_event_b_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    aresetn |=> pb2_event_b == $past(event_out[PRS_EV_B]))
    else $error("event B not on its default pin");

  chk_event_c_dflt: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    aresetn && event_out[PRS_EV_C] && !event_output_route_q[PRS_EV_C] |=> pc2_event_c && !pc7_event_c)
    else $error("event C not on default pin");

  chk_event_d_alt: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    aresetn && event_out[PRS_EV_D] && event_output_route_q[PRS_EV_D] |=> pd7_event_d && !pd2_event_d)
    else $error("event D not on alternate pin");

  chk_serial12_fields: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    aresetn |=> serial1_pin_set == $past(serial_port_pin_route_q[3:2])
      && serial2_pin_set == $past(serial_port_pin_route_q[5:4]))
    else $error("serial 1 or 2 pin set mismatch");

  chk_single_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    !(pa2_event_a && pa7_event_a) && !(pc2_event_c && pc7_event_c) && !(pd2_event_d && pd7_event_d)
      && (logic_table_dflt_pin & logic_table_alt_pin) == 4'h0)
    else $error("routed signal on both pins");

  chk_pins_reset: assert property (@(posedge aclk) // [R13]
    !aresetn |=> !pa2_event_a && !pa7_event_a && !pb2_event_b && !pe2_event_e && !pf2_event_f
      && logic_table_dflt_pin == 4'h0 && logic_table_alt_pin == 4'h0 && serial3_pin_set == 2'h0)
    else $error("pins not cleared by reset");

endmodule

// ==== dv/prs_pin_route_select_tb.sv ====
// Self-checking bench for the pin route selector
`timescale 1ns/100ps
module prs_pin_route_select_tb;
  import prs_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [3:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [3:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [5:0]  event_out;
  logic [3:0]  logic_table_out;
  logic [8:0]  ev_pins;
  logic [3:0]  lt_dflt;
  logic [3:0]  lt_alt;
  logic [7:0]  ser_pins;
  int          miscompares;
  int          n_compared;

  prs_pin_route_select i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .event_out(event_out), .logic_table_out(logic_table_out),
    .pa2_event_a(ev_pins[0]), .pa7_event_a(ev_pins[1]), .pb2_event_b(ev_pins[2]),
    .pc2_event_c(ev_pins[3]), .pc7_event_c(ev_pins[4]), .pd2_event_d(ev_pins[5]), .pd7_event_d(ev_pins[6]),
    .pe2_event_e(ev_pins[7]), .pf2_event_f(ev_pins[8]),
    .logic_table_dflt_pin(lt_dflt), .logic_table_alt_pin(lt_alt),
    .serial0_pin_set(ser_pins[1:0]), .serial1_pin_set(ser_pins[3:2]),
    .serial2_pin_set(ser_pins[5:4]), .serial3_pin_set(ser_pins[7:6])
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      miscompares++;
    end
  endtask

  task automatic timed_out();
    miscompares++;
    $display("BAD %0t handshake timeout", $time);
    results();
  endtask

  // Holds each channel until its own ready is seen at a falling edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    logic [1:0] resp;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 16 && !(aw_ok && w_ok); n++) begin
      @(negedge aclk);
      if (s_axi_awready === 1'b1) aw_ok = 1'b1;
      if (s_axi_wready === 1'b1) w_ok = 1'b1;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    if (!(aw_ok && w_ok)) timed_out();
    for (int n = 0; n < 16 && !b_ok; n++) begin
      @(negedge aclk);
      b_ok = (s_axi_bvalid === 1'b1);
      resp = s_axi_bresp;
      @(posedge aclk);
      if (b_ok) s_axi_bready <= 1'b0;
    end
    if (!b_ok) timed_out();
    chk({30'h0, resp}, {30'h0, er}, "bresp");
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ok;
    logic ar_ok;
    ok = 1'b0;
    ar_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(negedge aclk);
      if (s_axi_arready === 1'b1) ar_ok = 1'b1;
      ok = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      if (ok) s_axi_rready <= 1'b0;
    end
    if (!ok) timed_out();
  endtask

  function automatic logic [8:0] ev_exp(input logic [7:0] s, input logic [5:0] e);
    return {e[5], e[4], e[3] & s[3], e[3] & ~s[3], e[2] & s[2], e[2] & ~s[2], e[1], e[0] & s[0], e[0] & ~s[0]};
  endfunction

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // All registers zero, every signal on its default pin
  task automatic test_reset_state();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 3; i++) begin
      axi_rd(4'(i * 4), d, r);
      chk(d, 32'h0, "reset value");
    end
    @(posedge aclk);
    event_out <= 6'h3F;
    logic_table_out <= 4'hF;
    @(posedge aclk);
    @(negedge aclk);
    chk({15'h0, ev_pins, ser_pins}, {15'h0, 9'h1AD, 8'h00}, "default pins");
    chk({24'h0, lt_dflt, lt_alt}, 32'h000000F0, "default lut pins");
    $display("test reset_state done");
  endtask

  task automatic test_event();
    logic [7:0]  wr [6] = '{8'hFF, 8'h00, 8'h01, 8'h04, 8'h08, 8'h32};
    logic [5:0]  ev [2] = '{6'h3F, 6'h2A};
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  s;
    for (int i = 0; i < 6; i++) begin
      axi_wr(PRS_ADDR_EVENT, {24'h0, wr[i]}, 4'hF, PRS_RESP_OKAY);
      axi_rd(PRS_ADDR_EVENT, d, r);
      s = wr[i] & 8'h0D;
      chk(d, {24'h0, s}, "event route");
      for (int j = 0; j < 2; j++) begin
        @(posedge aclk);
        event_out <= ev[j];
        @(posedge aclk);
        @(negedge aclk);
        chk({23'h0, ev_pins}, {23'h0, ev_exp(s, ev[j])}, "event pins");
      end
    end
    $display("test event done");
  endtask

  task automatic test_logic();
    logic [7:0]  wr [4] = '{8'hFF, 8'h00, 8'h05, 8'h0A};
    logic [3:0]  lt [2] = '{4'hF, 4'h6};
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  s;
    for (int i = 0; i < 4; i++) begin
      axi_wr(PRS_ADDR_LOGIC, {24'h0, wr[i]}, 4'hF, PRS_RESP_OKAY);
      axi_rd(PRS_ADDR_LOGIC, d, r);
      s = wr[i][3:0];
      chk(d, {28'h0, s}, "lut route");
      for (int j = 0; j < 2; j++) begin
        @(posedge aclk);
        logic_table_out <= lt[j];
        @(posedge aclk);
        @(negedge aclk);
        chk({24'h0, lt_dflt, lt_alt}, {24'h0, lt[j] & ~s, lt[j] & s}, "lut pins");
      end
    end
    $display("test logic done");
  endtask

  task automatic test_serial();
    logic [7:0]  wr [4] = '{8'hE4, 8'h1B, 8'hFF, 8'h00};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 4; i++) begin
      axi_wr(PRS_ADDR_SERIAL, {24'h0, wr[i]}, 4'hF, PRS_RESP_OKAY);
      axi_rd(PRS_ADDR_SERIAL, d, r);
      chk(d, {24'h0, wr[i]}, "serial route");
      @(negedge aclk);
      chk({24'h0, ser_pins}, {24'h0, wr[i]}, "serial pins");
    end
    $display("test serial done");
  endtask

  // Lane-0 strobe off and unmapped place leave the event route register untouched
  task automatic test_refused();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(PRS_ADDR_EVENT, 32'h0D, 4'hF, PRS_RESP_OKAY);
    axi_wr(PRS_ADDR_EVENT, 32'h00, 4'hE, PRS_RESP_OKAY);
    axi_wr(4'hC, 32'hFF, 4'hF, PRS_RESP_SLVERR);
    axi_rd(4'hC, d, r);
    chk({d[29:0], r}, {30'h0, PRS_RESP_SLVERR}, "unmapped read");
    axi_rd(PRS_ADDR_EVENT, d, r);
    chk(d, 32'h0D, "event kept");
    $display("test refused done");
  endtask

  task automatic test_reset_mid();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(PRS_ADDR_SERIAL, 32'hFF, 4'hF, PRS_RESP_OKAY);
    axi_wr(PRS_ADDR_LOGIC, 32'h0F, 4'hF, PRS_RESP_OKAY);
    do_reset();
    test_reset_state();
    $display("test reset_mid done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, event_out, logic_table_out} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset_state();
    test_event();
    test_logic();
    test_serial();
    test_refused();
    test_reset_mid();
    results();
  end
endmodule
